// *** afs_map.vh ***
// constants for the converter fifo sequencer
`ifndef AFS_MAP_VH
`define AFS_MAP_VH
// ----------------------------------------
// widths and limits
// ----------------------------------------
`define AFS_CH_W        5
`define AFS_RES_W       16
`define AFS_DEP_W       3
`define AFS_MAX_DEPTH   8
`define AFS_PTR_W       3
`define AFS_CNT_W       4
// ----------------------------------------
// conversion clock choices
// ----------------------------------------
`define AFS_CLK_BUS     2'h0
`define AFS_CLK_BUS_HALF 2'h1
`define AFS_CLK_ALT     2'h2
`define AFS_CLK_ASYNC   2'h3
// ----------------------------------------
// reset values
// ----------------------------------------
`define AFS_CH_RST      5'h1f
`define AFS_RES_RST     16'h0000
`endif

// *** afs_fifo_store.v ***
// small indexed store used for the channel queue
`timescale 1ns/1ps
`default_nettype none
module afs_fifo_store #(
  parameter WIDTH = 16,
  parameter DEPTH = 8,
  parameter AW    = 3
) (
  input  wire             sys_clk,
  input  wire             rstn,
  input  wire             wr_en,
  input  wire [AW-1:0]    wr_addr,
  input  wire [WIDTH-1:0] wr_data,
  input  wire [AW-1:0]    rd_addr,
  output wire [WIDTH-1:0] rd_data
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  integer i;
  always @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      for (i = 0; i < DEPTH; i = i + 1) begin
        mem[i] <= {WIDTH{1'b0}};
      end
    end else if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end
  assign rd_data = mem[rd_addr];
endmodule
`default_nettype wire

// *** afs_seq.v ***
// converter fifo sequencer: channel queue, result queue, completion flag
`timescale 1ns/1ps
`default_nettype none
`include "afs_map.vh"
module afs_seq #(
  parameter DEPTH = `AFS_MAX_DEPTH
) (
  input  wire                  sys_clk,
  input  wire                  rstn,
  input  wire [`AFS_DEP_W-1:0] fifo_depth_field,
  input  wire                  scan_mode_enable,
  input  wire                  compare_combine_select,
  input  wire                  compare_enable,
  input  wire                  hw_trigger_select,
  input  wire                  continuous_mode_bit,
  input  wire                  completion_irq_enable,
  input  wire [1:0]            conv_clock_select,
  input  wire                  cfg_write,
  input  wire                  ch_write,
  input  wire [`AFS_CH_W-1:0]  ch_write_data,
  input  wire                  hw_trigger,
  input  wire                  wait_mode,
  input  wire                  stop_mode,
  input  wire                  conv_done,
  input  wire [`AFS_RES_W-1:0] conv_result,
  input  wire                  cmp_true,
  input  wire                  res_high_read,
  input  wire                  res_low_read,
  output reg                   conv_start_r,
  output reg  [`AFS_CH_W-1:0]  conv_channel_r,
  output reg  [`AFS_CH_W-1:0]  channel_select_field_r,
  output reg                   conversion_complete_flag_r,
  output reg                   irq_r,
  output reg  [`AFS_RES_W-1:0] result_r,
  output reg                   read_block_r,
  output reg                   busy_r
);
  // ----------------------------------------
  // states
  // ----------------------------------------
  localparam ST_IDLE = 4'h1;
  localparam ST_CONV = 4'h2;
  localparam ST_NEXT = 4'h4;
  localparam ST_DONE = 4'h8;
  reg [3:0] state_r;
  reg [3:0] state_nxt;

  // ----------------------------------------
  // queue state
  // ----------------------------------------
  reg  [`AFS_PTR_W-1:0] ch_wptr_r;
  reg  [`AFS_CNT_W-1:0] ch_cnt_r;
  reg  [`AFS_PTR_W-1:0] ch_rptr_r;
  reg  [`AFS_PTR_W-1:0] res_wptr_r;
  reg  [`AFS_PTR_W-1:0] res_rptr_r;
  reg  [`AFS_CNT_W-1:0] res_cnt_r;
  reg  [`AFS_CNT_W-1:0] done_cnt_r;
  reg                   cmp_any_r;
  reg                   cmp_all_r;
  reg                   trig_pend_r;
  // outside continuous mode a full queue starts once only; reuse needs a refill or trigger
  reg                   fresh_r;
  wire [`AFS_CH_W-1:0]  ch_rd;
  wire [`AFS_RES_W-1:0] res_rd;

  wire fifo_on = (fifo_depth_field != {`AFS_DEP_W{1'b0}});
  wire [`AFS_CNT_W-1:0] depth_n = {1'b0, fifo_depth_field};
  wire async_clk = (conv_clock_select == `AFS_CLK_ASYNC);
  // every clock but the async one dies in stop; all four run in wait
  wire stop_kill = stop_mode && !async_clk;
  // fifo sequences cannot be trusted across stop, so they are dropped
  wire stop_fifo = stop_mode && fifo_on;
  wire abort = cfg_write || ch_write || stop_kill || stop_fifo;
  wire hold = read_block_r && fifo_on;
  wire queue_full = scan_mode_enable ? (ch_cnt_r != 4'h0)
                                     : (ch_cnt_r >= depth_n);
  wire last_conv = (done_cnt_r + 4'h1 >= depth_n);
  wire cmp_ok = !compare_enable ||
    (compare_combine_select ? (cmp_all_r && cmp_true)
                            : (cmp_any_r || cmp_true));
  // a fetch outside ST_NEXT, or any fetch in scan mode, reads entry zero
  wire [`AFS_PTR_W-1:0] fetch_ptr = (scan_mode_enable || state_r != ST_NEXT)
                                    ? 3'h0 : ch_rptr_r;
  wire ch_restart = (ch_cnt_r == 4'h0) || (ch_cnt_r >= depth_n);
  wire trig_ok = !hw_trigger_select || hw_trigger || trig_pend_r;
  wire flag_set;

  afs_fifo_store #(
    .WIDTH (`AFS_CH_W),
    .DEPTH (DEPTH),
    .AW    (`AFS_PTR_W)
  ) u_ch_store (
    .sys_clk (sys_clk),
    .rstn    (rstn),
    .wr_en   (ch_write && fifo_on),
    .wr_addr ((scan_mode_enable || ch_restart) ? 3'h0 : ch_wptr_r),
    .wr_data (ch_write_data),
    .rd_addr (fetch_ptr),
    .rd_data (ch_rd)
  );

  // a result store of its own keeps queued results apart from channels
  reg [`AFS_RES_W-1:0] res_mem [0:DEPTH-1];
  integer k;
  always @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      for (k = 0; k < DEPTH; k = k + 1) begin
        res_mem[k] <= `AFS_RES_RST;
      end
    end else if (state_r == ST_CONV && conv_done && !hold && fifo_on) begin
      res_mem[res_wptr_r] <= conv_result;
    end
  end
  assign res_rd = res_mem[res_rptr_r];

  // ----------------------------------------
  // sequencer
  // ----------------------------------------
  always @* begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE: begin
        if (!abort && fifo_on && queue_full && trig_ok && !hold &&
            (fresh_r || hw_trigger_select)) begin
          state_nxt = ST_CONV;
        end else if (!abort && !fifo_on && trig_ok && !stop_kill &&
                     (continuous_mode_bit || hw_trigger)) begin
          state_nxt = ST_CONV;
        end
      end
      ST_CONV: begin
        if (abort) begin
          state_nxt = ST_IDLE;
        end else if (conv_done && !hold) begin
          if (!fifo_on || last_conv) begin
            state_nxt = ST_DONE;
          end else begin
            state_nxt = ST_NEXT;
          end
        end
      end
      ST_NEXT: begin
        if (abort) begin
          state_nxt = ST_IDLE;
        end else if (trig_ok && !hold) begin
          state_nxt = ST_CONV;
        end
      end
      ST_DONE: begin
        if (abort) begin
          state_nxt = ST_IDLE;
        end else if (continuous_mode_bit) begin
          state_nxt = ST_CONV;
        end else begin
          state_nxt = ST_IDLE;
        end
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  assign flag_set = (state_r == ST_CONV) && conv_done && !hold && !abort &&
                    (!fifo_on || last_conv) && cmp_ok;
  wire start_now = (state_nxt == ST_CONV) && (state_r != ST_CONV);
  wire res_pop = res_low_read && fifo_on;

  always @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      state_r                    <= ST_IDLE;
      ch_wptr_r                  <= 3'h0;
      ch_cnt_r                   <= 4'h0;
      ch_rptr_r                  <= 3'h0;
      res_wptr_r                 <= 3'h0;
      res_rptr_r                 <= 3'h0;
      res_cnt_r                  <= 4'h0;
      done_cnt_r                 <= 4'h0;
      cmp_any_r                  <= 1'b0;
      cmp_all_r                  <= 1'b1;
      trig_pend_r                <= 1'b0;
      fresh_r                    <= 1'b0;
      conv_start_r               <= 1'b0;
      conv_channel_r             <= `AFS_CH_RST;
      channel_select_field_r     <= `AFS_CH_RST;
      conversion_complete_flag_r <= 1'b0;
      irq_r                      <= 1'b0;
      result_r                   <= `AFS_RES_RST;
      read_block_r               <= 1'b0;
      busy_r                     <= 1'b0;
    end else begin
      state_r      <= state_nxt;
      conv_start_r <= start_now && !abort;
      busy_r       <= (state_nxt != ST_IDLE);
      // hardware trigger arriving mid-conversion is remembered for the fetch
      if (ch_write && fifo_on) begin
        fresh_r <= 1'b1;
      end else if (cfg_write || (start_now && state_r == ST_IDLE)) begin
        fresh_r <= 1'b0;
      end
      if (start_now) begin
        trig_pend_r <= 1'b0;
      end else if (hw_trigger && state_r != ST_IDLE) begin
        trig_pend_r <= 1'b1;
      end
      if (ch_write) begin
        // a write into an empty or full queue starts a new fill; results are always discarded
        ch_wptr_r  <= fifo_on && !scan_mode_enable ? 3'h1 : 3'h0;
        ch_cnt_r   <= 4'h1;
        ch_rptr_r  <= 3'h0;
        done_cnt_r <= 4'h0;
        res_wptr_r <= 3'h0;
        res_rptr_r <= 3'h0;
        res_cnt_r  <= 4'h0;
        if (!fifo_on) begin
          conv_channel_r         <= ch_write_data;
          channel_select_field_r <= ch_write_data;
        end
        if (ch_cnt_r < depth_n && !scan_mode_enable && fifo_on &&
            ch_cnt_r != 4'h0) begin
          ch_wptr_r <= ch_wptr_r + 3'h1;
          ch_cnt_r  <= ch_cnt_r + 4'h1;
        end
      end else if (start_now && fifo_on) begin
        conv_channel_r         <= ch_rd;
        channel_select_field_r <= ch_rd;
        ch_rptr_r              <= ch_rptr_r + 3'h1;
        if (state_r != ST_NEXT) begin
          done_cnt_r <= 4'h0;
          ch_rptr_r  <= 3'h1;
          res_wptr_r <= 3'h0;
          res_cnt_r  <= 4'h0;
          res_rptr_r <= 3'h0;
          cmp_any_r  <= 1'b0;
          cmp_all_r  <= 1'b1;
        end
      end else if (state_r == ST_CONV && conv_done && !hold && !abort) begin
        if (fifo_on) begin
          res_wptr_r <= res_wptr_r + 3'h1;
          res_cnt_r  <= res_cnt_r + 4'h1;
          done_cnt_r <= done_cnt_r + 4'h1;
          cmp_any_r  <= cmp_any_r || cmp_true;
          cmp_all_r  <= cmp_all_r && cmp_true;
        end else if (cmp_ok) begin
          result_r <= conv_result;
        end
      end else if (res_pop && res_cnt_r != 4'h0) begin
        res_rptr_r <= res_rptr_r + 3'h1;
        res_cnt_r  <= res_cnt_r - 4'h1;
      end
      if (fifo_on) begin
        result_r <= res_rd;
      end
      // high read opens a pair, low read closes it
      if (res_high_read) begin
        read_block_r <= 1'b1;
      end else if (res_low_read) begin
        read_block_r <= 1'b0;
      end
      // set wins over the read that clears the flag
      if (flag_set) begin
        conversion_complete_flag_r <= 1'b1;
      end else if (res_low_read || ch_write || cfg_write) begin
        conversion_complete_flag_r <= 1'b0;
      end
      irq_r <= (flag_set || conversion_complete_flag_r) &&
               completion_irq_enable && !(stop_fifo);
    end
  end
endmodule
`default_nettype wire

// *** afs_seq_assertions.sv ***
// port-level checks on the converter fifo sequencer
`timescale 1ns/1ps
`default_nettype none
module afs_seq_assertions (
  input wire logic       sys_clk,
  input wire logic       rstn,
  input wire logic [2:0] fifo_depth_field,
  input wire logic       scan_mode_enable,
  input wire logic       completion_irq_enable,
  input wire logic [1:0] conv_clock_select,
  input wire logic       ch_write,
  input wire logic       stop_mode,
  input wire logic       res_high_read,
  input wire logic       res_low_read,
  input wire logic       conv_start_r,
  input wire logic [4:0] conv_channel_r,
  input wire logic [4:0] channel_select_field_r,
  input wire logic       conversion_complete_flag_r,
  input wire logic       irq_r,
  input wire logic       read_block_r,
  input wire logic       busy_r
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  // ----------------------------------------
  // sequencing
  // ----------------------------------------
  start_pulse_a: assert property (conv_start_r |=> !conv_start_r)
    else $error("start pulse too long");
  fill_first_a: assert property (ch_write && fifo_depth_field > 3'h1
    && !scan_mode_enable |=> !conv_start_r) else $error("early start");
  stop_idle_a: assert property ($rose(stop_mode)
    && conv_clock_select != 2'h3 |-> ##[1:2] !busy_r) else $error("no abort");
  readback_a: assert property (conv_start_r ##1 !ch_write [*2]
    |-> channel_select_field_r == conv_channel_r) else $error("readback");
  // ----------------------------------------
  // completion and result reads
  // ----------------------------------------
  irq_set_a: assert property ($rose(conversion_complete_flag_r)
    && completion_irq_enable |-> ##[0:1] irq_r) else $error("irq missing");
  irq_mask_a: assert property (!completion_irq_enable
    && !$past(completion_irq_enable) |-> !irq_r) else $error("irq masked");
  block_set_a: assert property (res_high_read && !res_low_read
    |=> read_block_r) else $error("block not set");
  block_clr_a: assert property (res_low_read && !res_high_read
    |=> !read_block_r) else $error("block not cleared");
  hold_block_a: assert property ((read_block_r
    && fifo_depth_field != 3'h0) [*3] |-> !conv_start_r) else $error("held");
  cover property (conversion_complete_flag_r && irq_r);
  cover property (read_block_r [*3]);
  cover property ($rose(stop_mode) && busy_r);
endmodule
bind afs_seq afs_seq_assertions i_chk (.sys_clk(sys_clk), .rstn(rstn),
  .fifo_depth_field(fifo_depth_field), .scan_mode_enable(scan_mode_enable),
  .completion_irq_enable(completion_irq_enable), .ch_write(ch_write),
  .conv_clock_select(conv_clock_select), .stop_mode(stop_mode),
  .res_high_read(res_high_read), .res_low_read(res_low_read),
  .conv_start_r(conv_start_r), .conv_channel_r(conv_channel_r),
  .channel_select_field_r(channel_select_field_r), .irq_r(irq_r),
  .conversion_complete_flag_r(conversion_complete_flag_r),
  .read_block_r(read_block_r), .busy_r(busy_r));
`default_nettype wire

// *** afs_core_model.sv ***
// converter core stand-in answering each start after a short or long delay unless busy falls first
`timescale 1ns/1ps
`default_nettype none
module afs_core_model (
  input  wire logic        sys_clk,
  input  wire logic        start,
  input  wire logic        busy,
  input  wire logic [4:0]  chan,
  input  wire logic        slow,
  output var  logic        done,
  output var  logic [15:0] result
);
  integer     wt = 0;
  logic [4:0] ch_q = 5'h0;
  initial done = 1'b0;
  initial result = 16'h0;
  // result toggles outside the done cycle so a value sampled one cycle late does not match
  always @(negedge sys_clk) begin
    done <= 1'b0;
    result <= ~result;
    if (wt == 1) begin
      done <= 1'b1;
      result <= 16'ha0a0 ^ {11'h0, ch_q};
    end
    if (wt > 0) wt <= wt - 1;
    if (start) begin
      wt <= slow ? 12 : 2;
      ch_q <= chan;
    end else if (!busy) wt <= 0;
  end
endmodule
`default_nettype wire

// *** afs_seq_tb.sv ***
// self-checking bench for the converter fifo sequencer
`timescale 1ns/1ps
`default_nettype none
module afs_seq_tb;
  logic        sys_clk = 1'b0;
  logic        rstn = 1'b0;
  logic        scan = 1'b0;
  logic        hw_sel = 1'b0;
  logic        cont = 1'b0;
  logic        ien = 1'b1;
  logic        cfg_wr = 1'b0;
  logic        ch_wr = 1'b0;
  logic        trig = 1'b0;
  logic        wait_m = 1'b0;
  logic        stop_m = 1'b0;
  logic        rh = 1'b0;
  logic        rl = 1'b0;
  logic        slow = 1'b0;
  logic [1:0]  csel = 2'h0;
  logic [4:0]  ch_d = 5'h0;
  wire         start, done, flag, irq, blk, busy;
  wire  [4:0]  conv_ch, ch_rb;
  wire  [15:0] cres, res;
  logic [4:0]  st_ch [0:7];
  integer      n_start = 0, n_mismatch = 0, checked = 0, cyc = 0, m;
  afs_seq i_dut (.sys_clk(sys_clk), .rstn(rstn), .fifo_depth_field(3'h2),
    .scan_mode_enable(scan), .compare_combine_select(1'b0),
    .compare_enable(1'b0), .hw_trigger_select(hw_sel),
    .continuous_mode_bit(cont), .completion_irq_enable(ien),
    .conv_clock_select(csel), .cfg_write(cfg_wr), .ch_write(ch_wr),
    .ch_write_data(ch_d), .hw_trigger(trig), .wait_mode(wait_m),
    .stop_mode(stop_m), .conv_done(done), .conv_result(cres),
    .cmp_true(1'b1), .res_high_read(rh), .res_low_read(rl),
    .conv_start_r(start), .conv_channel_r(conv_ch),
    .channel_select_field_r(ch_rb), .conversion_complete_flag_r(flag),
    .irq_r(irq), .result_r(res), .read_block_r(blk), .busy_r(busy));
  afs_core_model i_core (.sys_clk(sys_clk), .start(start), .busy(busy),
    .chan(conv_ch), .slow(slow), .done(done), .result(cres));
  always #2.5 sys_clk = ~sys_clk;
  // ----------------------------------------
  // start log and hang guard
  // ----------------------------------------
  always @(negedge sys_clk) begin
    cyc = cyc + 1;
    if (start === 1'b1) begin
      st_ch[n_start[2:0]] = conv_ch;
      n_start = n_start + 1;
    end
    if (cyc > 2000) begin
      n_mismatch = n_mismatch + 1;
      stop_test;
    end
  end
  task stop_test;
    if (n_mismatch == 0 && checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task chk(input string nm, input [15:0] exp, input [15:0] got);
    begin
      checked = checked + 1;
      if (got !== exp) begin
        n_mismatch = n_mismatch + 1;
        $display("unexpected %s: expected %h, seen %h", nm, exp, got);
      end
    end
  endtask
  task go(input integer n);
    repeat (n) @(negedge sys_clk);
  endtask
  task wr_ch(input [4:0] c);
    begin
      go(1);
      ch_d = c;
      ch_wr = 1'b1;
      go(1);
      ch_wr = 1'b0;
    end
  endtask
  task trg;
    begin
      go(1);
      trig = 1'b1;
      go(1);
      trig = 1'b0;
    end
  endtask
  // high then low; the gap keeps the block up for a few cycles
  task rd(input [15:0] exp);
    begin
      chk("result", exp, res);
      go(1);
      rh = 1'b1;
      go(1);
      rh = 1'b0;
      go(2);
      rl = 1'b1;
      go(1);
      rl = 1'b0;
      go(2);
    end
  endtask
  task fill;
    begin
      n_start = 0;
      wr_ch(5'h3);
      wr_ch(5'h5);
    end
  endtask
  initial begin
    go(4);
    rstn = 1'b1;
    for (m = 0; m < 2; m = m + 1) begin
      hw_sel = m[0];
      wait_m = m[0];
      csel = m[0] ? 2'h2 : 2'h1;
      fill;
      if (m[0]) begin
        go(10);
        chk("starts", 16'h0, 16'(n_start));
        trg;
        go(20);
        chk("starts", 16'h1, 16'(n_start));
        chk("flag", 16'h0, 16'(flag));
        trg;
      end
      go(20);
      chk("flag", 16'h1, 16'(flag));
      chk("irq", 16'h1, 16'(irq));
      chk("chan0", 16'h3, 16'(st_ch[0]));
      chk("chan1", 16'h5, 16'(st_ch[1]));
      rd(16'ha0a3);
      rd(16'ha0a5);
      chk("starts", 16'h2, 16'(n_start));
    end
    hw_sel = 1'b0;
    wait_m = 1'b0;
    slow = 1'b1;
    fill;
    go(4);
    wr_ch(5'h7);
    go(30);
    chk("starts", 16'h1, 16'(n_start));
    chk("flag", 16'h0, 16'(flag));
    wr_ch(5'h9);
    go(40);
    chk("chan1", 16'h7, 16'(st_ch[1]));
    chk("chan2", 16'h9, 16'(st_ch[2]));
    fill;
    go(4);
    stop_m = 1'b1;
    go(3);
    chk("busy", 16'h0, 16'(busy));
    stop_m = 1'b0;
    go(40);
    chk("starts", 16'h1, 16'(n_start));
    slow = 1'b0;
    cont = 1'b1;
    fill;
    go(25);
    chk("chan2", 16'h3, 16'(st_ch[2]));
    chk("chan3", 16'h5, 16'(st_ch[3]));
    go(1);
    cfg_wr = 1'b1;
    go(1);
    cfg_wr = 1'b0;
    cont = 1'b0;
    scan = 1'b1;
    ien = 1'b0;
    go(10);
    n_start = 0;
    wr_ch(5'h6);
    go(20);
    chk("flag", 16'h1, 16'(flag));
    chk("irq", 16'h0, 16'(irq));
    chk("chan1", 16'h6, 16'(st_ch[1]));
    rd(16'ha0a6);
    go(4);
    stop_test;
  end
endmodule
`default_nettype wire
